/* File: hdl/mpg_cfg.svh */
// Register indices, byte addresses, field positions and reset values of the port block
`ifndef MPG_CFG_SVH
`define MPG_CFG_SVH
`define MPG_AW 12
`define MPG_IDX_C_DATA 6'h02
`define MPG_IDX_D_DATA 6'h03
`define MPG_IDX_E_DATA 6'h08
`define MPG_IDX_C_DIR 6'h10
`define MPG_IDX_D_DIR 6'h11
`define MPG_IDX_E_DIR 6'h12
`define MPG_IDX_C_PU 6'h13
`define MPG_IDX_D_PU 6'h14
`define MPG_IDX_CTRL 6'h15
`define MPG_BA_C_DATA {4'h0, `MPG_IDX_C_DATA, 2'b00}
`define MPG_BA_D_DATA {4'h0, `MPG_IDX_D_DATA, 2'b00}
`define MPG_BA_E_DATA {4'h0, `MPG_IDX_E_DATA, 2'b00}
`define MPG_BA_C_DIR {4'h0, `MPG_IDX_C_DIR, 2'b00}
`define MPG_BA_D_DIR {4'h0, `MPG_IDX_D_DIR, 2'b00}
`define MPG_BA_E_DIR {4'h0, `MPG_IDX_E_DIR, 2'b00}
`define MPG_BA_C_PU {4'h0, `MPG_IDX_C_PU, 2'b00}
`define MPG_BA_D_PU {4'h0, `MPG_IDX_D_PU, 2'b00}
`define MPG_BA_CTRL {4'h0, `MPG_IDX_CTRL, 2'b00}
`define MPG_CTRL_SPE 0
`define MPG_CTRL_SERIAL_PERIPHERAL_MASTER_SELECT 1
`define MPG_CTRL_ASYNC 2
`define MPG_CTRL_ELS0_LO 3
`define MPG_CTRL_ELS0_HI 4
`define MPG_CTRL_ELS1_LO 5
`define MPG_CTRL_ELS1_HI 6
`define MPG_CTRL_OSC_OUT 7
`define MPG_CTRL_OSC_IN 8
`define MPG_CTRL_CLKGEN 9
`define MPG_DIR7_RST 7'h00
`define MPG_DIR8_RST 8'h00
`define MPG_DIR5_RST 5'h00
`define MPG_PU7_RST 7'h00
`define MPG_PU8_RST 8'h00
`define MPG_CTRL_RST 10'h000
`define MPG_RESP_OKAY 2'h0
`define MPG_RESP_SLVERR 2'h2
`endif

/* File: hdl/mpg_gpio.sv */
// Three-port pin logic with peripheral hand-over, reached over AXI4-Lite
// Function
// - Third-port pull-up bit one connects, zero disconnects
// - Pull-up only on input, off when output
// - Fourth port has eight pull-up enable bits
// - Fourth and fifth latches survive reset
// - Direction one drives pin; reset clears fourth
// - Reset clears fifth-port direction bits
// - Fourth-port read: latch if output, else pin
// - Fifth-port read: latch if output, else pin
// - Data writes with lane 0 strobe update latch, except oscillator-owned fifth-port bits
// - Timer edge/level bits claim shared pins
// - Serial clock pin is GPIO when disabled
// - MOSI and MISO are GPIO when disabled
// - Slave select GPIO when disabled or master
// - Serial-owned pins: direction only steers reads
// - Enabled slave select ignores its direction bit
// - Fifth bits 3 and 4 become oscillator pins
// - Oscillator pins ignore writes, read as zero
// - Receive pin is GPIO when async disabled
// - Transmit pin is GPIO when async disabled
// - Async-owned pins: direction only steers reads
// - Third-port read: latch if output, else pin
`include "mpg_cfg.svh"
module mpg_gpio
  import mpg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire mpg_pin_in_t pins_in,
  input wire mpg_alt_t alt_drive,
  output mpg_pin_drive_t pin_drive,
  output mpg_pin_in_t pin_levels
);

  mpg_state_t st_reg;
  mpg_state_t st_next;
  logic [6:0] lvl_c;
  logic [7:0] lvl_d;
  logic [4:0] lvl_e;
  logic [7:0] d_own;
  logic [4:0] e_own;
  logic [4:0] e_osc;
  logic [7:0] d_oe_eff;
  logic [7:0] d_val_eff;
  logic [4:0] e_oe_eff;
  logic [4:0] e_val_eff;
  logic [7:0] wd8;
  logic wr_commit;
  logic d_wr_seen;

  // Filtered pin levels per port
  assign lvl_c = st_reg.filt[6:0];
  assign lvl_d = st_reg.filt[14:7];
  assign lvl_e = st_reg.filt[19:15];
  assign wd8 = st_reg.w_data[7:0];
  assign wr_commit = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;

  // Which pins belong to a peripheral
  assign d_own[7] = |st_reg.ctrl[`MPG_CTRL_ELS1_HI:`MPG_CTRL_ELS1_LO];
  assign d_own[6] = |st_reg.ctrl[`MPG_CTRL_ELS0_HI:`MPG_CTRL_ELS0_LO];
  assign d_own[5:4] = 2'h0;
  assign d_own[3] = st_reg.ctrl[`MPG_CTRL_SPE];
  assign d_own[2:1] = {2{st_reg.ctrl[`MPG_CTRL_SPE]}};
  assign d_own[0] = st_reg.ctrl[`MPG_CTRL_SPE] && !st_reg.ctrl[`MPG_CTRL_SERIAL_PERIPHERAL_MASTER_SELECT];
  assign e_osc[4] = st_reg.ctrl[`MPG_CTRL_OSC_IN] && st_reg.ctrl[`MPG_CTRL_CLKGEN];
  assign e_osc[3] = st_reg.ctrl[`MPG_CTRL_OSC_OUT] && st_reg.ctrl[`MPG_CTRL_CLKGEN];
  assign e_osc[2:0] = 3'h0;
  assign e_own[4:3] = e_osc[4:3];
  assign e_own[2] = 1'b0;
  assign e_own[1] = st_reg.ctrl[`MPG_CTRL_ASYNC];
  assign e_own[0] = st_reg.ctrl[`MPG_CTRL_ASYNC];

  // Owned pins follow the peripheral, oscillator pins a fixed enable (bit 3 driven, bit 4 not), others their direction bit
  assign d_oe_eff = (d_own & alt_drive.d_oe) | (~d_own & st_reg.d_dir);
  assign d_val_eff = (d_own & alt_drive.d_out) | (~d_own & st_reg.d_latch);
  assign e_oe_eff = (e_own & ~e_osc & alt_drive.e_oe) | (e_osc & 5'h08) | (~e_own & st_reg.e_dir);
  assign e_val_eff = (e_own & alt_drive.e_out) | (~e_own & st_reg.e_latch);

  // Register read decode: returns hit flag above the data word
  function automatic logic [32:0] read_reg(input logic [11:0] addr);
    logic [32:0] res;
    res = 33'h000000000;
    case (addr)
      `MPG_BA_C_DATA: res = {1'b1, 25'h0, (st_reg.c_dir & st_reg.c_latch) | (~st_reg.c_dir & lvl_c)};
      `MPG_BA_D_DATA: res = {1'b1, 24'h0, (st_reg.d_dir & st_reg.d_latch) | (~st_reg.d_dir & lvl_d)};
      `MPG_BA_E_DATA: res = {1'b1, 27'h0, ((st_reg.e_dir & st_reg.e_latch) | (~st_reg.e_dir & lvl_e)) & ~e_osc};
      `MPG_BA_C_DIR: res = {1'b1, 25'h0, st_reg.c_dir};
      `MPG_BA_D_DIR: res = {1'b1, 24'h0, st_reg.d_dir};
      `MPG_BA_E_DIR: res = {1'b1, 27'h0, st_reg.e_dir};
      `MPG_BA_C_PU: res = {1'b1, 25'h0, st_reg.c_pu};
      `MPG_BA_D_PU: res = {1'b1, 24'h0, st_reg.d_pu};
      `MPG_BA_CTRL: res = {1'b1, 22'h0, st_reg.ctrl};
      default: res = 33'h000000000;
    endcase
    return res;
  endfunction : read_reg

  // Next state: synchronisers, bus slave, registers and pin drive
  always_comb begin
    logic [32:0] rd;
    logic hit;
    rd = read_reg(araddr);
    hit = 1'b0;
    st_next = st_reg;
    // Three-stage sampling; a change counts when stages two and three agree
    st_next.sy1 = pins_in;
    st_next.sy2 = st_reg.sy1;
    st_next.sy3 = st_reg.sy2;
    st_next.filt = (~(st_reg.sy2 ^ st_reg.sy3) & st_reg.sy3) | ((st_reg.sy2 ^ st_reg.sy3) & st_reg.filt);
    // Write address and data are taken independently
    if (awvalid && st_reg.aw_rdy) begin
      st_next.aw_addr = awaddr;
      st_next.aw_hold = 1'b1;
      st_next.aw_rdy = 1'b0;
    end
    if (wvalid && st_reg.w_rdy) begin
      st_next.w_data = wdata;
      st_next.w_strb0 = wstrb[0];
      st_next.w_hold = 1'b1;
      st_next.w_rdy = 1'b0;
    end
    // Commit once both halves are held
    if (wr_commit) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `MPG_RESP_OKAY;
      case (st_reg.aw_addr)
        `MPG_BA_C_DATA: begin
          if (st_reg.w_strb0) st_next.c_latch = wd8[6:0];
        end
        `MPG_BA_D_DATA: begin
          if (st_reg.w_strb0) st_next.d_latch = wd8;
        end
        `MPG_BA_E_DATA: begin
          if (st_reg.w_strb0) st_next.e_latch = (wd8[4:0] & ~e_osc) | (st_reg.e_latch & e_osc);
        end
        `MPG_BA_C_DIR: begin
          if (st_reg.w_strb0) st_next.c_dir = wd8[6:0];
        end
        `MPG_BA_D_DIR: begin
          if (st_reg.w_strb0) st_next.d_dir = wd8;
        end
        `MPG_BA_E_DIR: begin
          if (st_reg.w_strb0) st_next.e_dir = wd8[4:0];
        end
        `MPG_BA_C_PU: begin
          if (st_reg.w_strb0) st_next.c_pu = wd8[6:0];
        end
        `MPG_BA_D_PU: begin
          if (st_reg.w_strb0) st_next.d_pu = wd8;
        end
        `MPG_BA_CTRL: begin
          if (st_reg.w_strb0) st_next.ctrl[7:0] = wd8;
          if (wstrb_hi_q(st_reg.w_data)) st_next.ctrl[9:8] = st_reg.w_data[9:8];
        end
        default: st_next.bresp = `MPG_RESP_SLVERR;
      endcase
    end
    // Write response handshake re-opens both channels
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
      st_next.aw_rdy = 1'b1;
      st_next.w_rdy = 1'b1;
    end
    // Read: data captured at the address handshake
    if (arvalid && st_reg.ar_rdy) begin
      hit = rd[32];
      st_next.rdata = rd[31:0];
      st_next.rresp = hit ? `MPG_RESP_OKAY : `MPG_RESP_SLVERR;
      st_next.rvalid = 1'b1;
      st_next.ar_rdy = 1'b0;
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
      st_next.ar_rdy = 1'b1;
    end
    // Pin drive, pull-ups only where the pin is not driven
    st_next.drive.c_oe = st_reg.c_dir;
    st_next.drive.c_out = st_reg.c_dir & st_reg.c_latch;
    st_next.drive.c_pu = st_reg.c_pu & ~st_reg.c_dir;
    st_next.drive.d_oe = d_oe_eff;
    st_next.drive.d_out = d_oe_eff & d_val_eff;
    st_next.drive.d_pu = st_reg.d_pu & ~d_oe_eff;
    st_next.drive.e_oe = e_oe_eff;
    st_next.drive.e_out = e_oe_eff & e_val_eff;
    // Synchronous reset; the data latches are left as they are
    if (!aresetn) begin
      st_next.aw_rdy = 1'b1;
      st_next.w_rdy = 1'b1;
      st_next.ar_rdy = 1'b1;
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.aw_addr = 12'h000;
      st_next.w_data = 32'h00000000;
      st_next.w_strb0 = 1'b0;
      st_next.bvalid = 1'b0;
      st_next.bresp = `MPG_RESP_OKAY;
      st_next.rvalid = 1'b0;
      st_next.rresp = `MPG_RESP_OKAY;
      st_next.rdata = 32'h00000000;
      st_next.c_latch = st_reg.c_latch;
      st_next.d_latch = st_reg.d_latch;
      st_next.e_latch = st_reg.e_latch;
      st_next.c_dir = `MPG_DIR7_RST;
      st_next.d_dir = `MPG_DIR8_RST;
      st_next.e_dir = `MPG_DIR5_RST;
      st_next.c_pu = `MPG_PU7_RST;
      st_next.d_pu = `MPG_PU8_RST;
      st_next.ctrl = `MPG_CTRL_RST;
      st_next.sy1 = 20'h00000;
      st_next.sy2 = 20'h00000;
      st_next.sy3 = 20'h00000;
      st_next.filt = 20'h00000;
      st_next.drive = '0;
    end
  end

  // Upper control bits are written only with lane 0 enabled and data bits 31:10 all zero
  function automatic logic wstrb_hi_q(input logic [31:0] unused_data);
    return st_reg.w_strb0 && (unused_data[31:10] == 22'h000000);
  endfunction : wstrb_hi_q

  // State register
  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  // Check helper: fourth-port latch holds a known value once written; never reset
  always_ff @(posedge aclk) begin
    if (wr_commit && st_reg.aw_addr == `MPG_BA_D_DATA && st_reg.w_strb0) begin
      d_wr_seen <= 1'b1;
    end
  end

  // Outputs straight from the state flops
  assign awready = st_reg.aw_rdy;
  assign wready = st_reg.w_rdy;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = st_reg.ar_rdy;
  assign rvalid = st_reg.rvalid;
  assign rresp = st_reg.rresp;
  assign rdata = st_reg.rdata;
  assign pin_drive = st_reg.drive;
  assign pin_levels = mpg_pin_in_t'(st_reg.filt);

  // Checks
  default clocking ck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd(logic [11:0] a);
    arvalid && st_reg.ar_rdy && araddr == a;
  endsequence
  sequence s_wr(logic [11:0] a);
    wr_commit && st_reg.aw_addr == a && st_reg.w_strb0;
  endsequence
  sequence s_spi_off;
    !st_reg.ctrl[`MPG_CTRL_SPE] [*2];
  endsequence

  AST_PU_C_ONLY_INPUT: assert property (##1 pin_drive.c_pu == ($past(st_reg.c_pu) & ~$past(st_reg.c_dir)))
    else $error("third-port pull-up wrong");
  AST_PU_D_NOT_DRIVEN: assert property ((pin_drive.d_pu & pin_drive.d_oe) == 8'h00)
    else $error("fourth-port pull-up on a driven pin");
  AST_PU_D_FOLLOWS: assert property (##1 pin_drive.d_pu == ($past(st_reg.d_pu) & ~$past(d_oe_eff)))
    else $error("fourth-port pull-up wrong");
  AST_LATCH_KEPT: assert property (disable iff (1'b0) $rose(aresetn) && d_wr_seen
      |-> st_reg.d_latch == $past(st_reg.d_latch))
    else $error("fourth-port latch lost at reset");
  AST_DIR_RESET: assert property (disable iff (1'b0) $rose(aresetn) |-> st_reg.d_dir == 8'h00 && st_reg.e_dir == 5'h00)
    else $error("direction not cleared by reset");
  AST_E_DIR_RESET_DRIVE: assert property (disable iff (1'b0) $rose(aresetn) |=> pin_drive.e_oe == 5'h00)
    else $error("fifth-port drives after reset");
  AST_READ_D: assert property (s_rd(`MPG_BA_D_DATA) |=> rvalid && rdata[7:0] ==
      (($past(st_reg.d_dir) & $past(st_reg.d_latch)) | (~$past(st_reg.d_dir) & $past(lvl_d))))
    else $error("fourth-port read mix wrong");
  AST_READ_E: assert property (s_rd(`MPG_BA_E_DATA) |=> rvalid && rdata[31:5] == 27'h0)
    else $error("fifth-port upper bits not zero");
  AST_WRITE_D: assert property (s_wr(`MPG_BA_D_DATA) |=> st_reg.d_latch == $past(wd8) && bvalid)
    else $error("fourth-port latch not written");
  AST_OSC_NO_WRITE: assert property (s_wr(`MPG_BA_E_DATA) && e_osc[3] |=> st_reg.e_latch[3] == $past(st_reg.e_latch[3]))
    else $error("oscillator pin latch written");
  AST_SPI_GPIO: assert property (s_spi_off |-> pin_drive.d_oe[3:0] == $past(st_reg.d_dir[3:0]))
    else $error("serial pins not returned to GPIO");
  AST_SS_MASTER: assert property (st_reg.ctrl[`MPG_CTRL_SERIAL_PERIPHERAL_MASTER_SELECT] |=> pin_drive.d_oe[0] == $past(st_reg.d_dir[0]))
    else $error("slave select not GPIO in master mode");
  AST_ASYNC_GPIO: assert property (!st_reg.ctrl[`MPG_CTRL_ASYNC] && !e_osc[4] && !e_osc[3]
      |=> pin_drive.e_oe == $past(st_reg.e_dir))
    else $error("async pins not released");
  AST_OSC_OUT: assert property (e_osc[3] |=> pin_drive.e_oe[3])
    else $error("oscillator output not driven");
endmodule : mpg_gpio

/* File: hdl/mpg_pkg.sv */
// Types shared by the port block and its users
package mpg_pkg;
  typedef struct packed {
    logic [4:0] e;
    logic [7:0] d;
    logic [6:0] c;
  } mpg_pin_in_t;
  typedef struct packed {
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [4:0] e_out;
    logic [4:0] e_oe;
  } mpg_alt_t;
  typedef struct packed {
    logic [6:0] c_out;
    logic [6:0] c_oe;
    logic [6:0] c_pu;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [7:0] d_pu;
    logic [4:0] e_out;
    logic [4:0] e_oe;
  } mpg_pin_drive_t;
  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic aw_hold;
    logic w_hold;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [6:0] c_latch;
    logic [6:0] c_dir;
    logic [6:0] c_pu;
    logic [7:0] d_latch;
    logic [7:0] d_dir;
    logic [7:0] d_pu;
    logic [4:0] e_latch;
    logic [4:0] e_dir;
    logic [9:0] ctrl;
    logic [19:0] sy1;
    logic [19:0] sy2;
    logic [19:0] sy3;
    logic [19:0] filt;
    mpg_pin_drive_t drive;
  } mpg_state_t;
endpackage : mpg_pkg

/* File: test/mpg_board.sv */
// Board-side model that resolves each pin from device drive, board drive and pull-ups
module mpg_board
  import mpg_pkg::*;
(
  input wire logic aclk,
  input wire mpg_pin_drive_t pin_drive,
  input wire mpg_pin_in_t ext,
  input wire mpg_pin_in_t ext_oe,
  output mpg_pin_in_t pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip;

  // Floating lines wander so an undriven pin never looks stable
  initial begin
    flip = 1'b0;
  end
  always @(posedge aclk) begin
    flip <= ~flip;
  end

  // Device drive wins, then the board, then the pull-up, else the wandering level
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pins_in.c[i] = pin_drive.c_oe[i] ? pin_drive.c_out[i] : ext_oe.c[i] ? ext.c[i] : pin_drive.c_pu[i] | flip;
    end
    for (int i = 0; i < 8; i++) begin
      pins_in.d[i] = pin_drive.d_oe[i] ? pin_drive.d_out[i] : ext_oe.d[i] ? ext.d[i] : pin_drive.d_pu[i] | flip;
    end
    for (int i = 0; i < 5; i++) begin
      pins_in.e[i] = pin_drive.e_oe[i] ? pin_drive.e_out[i] : ext_oe.e[i] ? ext.e[i] : flip;
    end
  end
endmodule : mpg_board

/* File: test/tb_multi_port_gpio_pin_logic.sv */
// Self-checking bench for the three-port pin block
`include "mpg_cfg.svh"
module tb_multi_port_gpio_pin_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import mpg_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  mpg_pin_in_t pins_in, pin_levels, ext, ext_oe;
  mpg_alt_t alt_drive;
  mpg_pin_drive_t pin_drive;
  int errors, comparisons;

  mpg_gpio dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pins_in(pins_in), .alt_drive(alt_drive), .pin_drive(pin_drive),
    .pin_levels(pin_levels));
  mpg_board board (.aclk(aclk), .pin_drive(pin_drive), .ext(ext), .ext_oe(ext_oe), .pins_in(pins_in));

  // Clock at 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  // Bus read with comparison of data and response
  task automatic rdck(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rdck

  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask : settle

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  task automatic t_reset_values;
    chk({2'b00, pin_drive.c_oe, pin_drive.c_pu, pin_drive.d_oe, pin_drive.d_pu}, 32'h0);
    chk({27'h0, pin_drive.e_oe}, 32'h0);
    rdck(`MPG_BA_D_DIR, {24'h0, `MPG_DIR8_RST}, `MPG_RESP_OKAY);
    rdck(`MPG_BA_E_DIR, {27'h0, `MPG_DIR5_RST}, `MPG_RESP_OKAY);
    rdck(`MPG_BA_C_PU, {25'h0, `MPG_PU7_RST}, `MPG_RESP_OKAY);
    rdck(`MPG_BA_D_PU, {24'h0, `MPG_PU8_RST}, `MPG_RESP_OKAY);
    rdck(`MPG_BA_CTRL, {22'h0, `MPG_CTRL_RST}, `MPG_RESP_OKAY);
  endtask : t_reset_values

  task automatic t_fourth;
    ext.d <= 8'h3C;
    wr(`MPG_BA_D_DATA, 32'hA5, `MPG_RESP_OKAY);
    wr(`MPG_BA_D_DIR, 32'h0F, `MPG_RESP_OKAY);
    settle;
    chk({24'h0, pin_drive.d_oe}, 32'h0F);
    chk({24'h0, pin_drive.d_out}, 32'h05);
    rdck(`MPG_BA_D_DATA, 32'h35, `MPG_RESP_OKAY);
    ext_oe.d <= 8'h00;
    wr(`MPG_BA_D_PU, 32'hFF, `MPG_RESP_OKAY);
    settle;
    chk({24'h0, pin_drive.d_pu}, 32'hF0);
    rdck(`MPG_BA_D_DATA, 32'hF5, `MPG_RESP_OKAY);
  endtask : t_fourth

  task automatic t_third;
    ext_oe.c <= 7'h00;
    wr(`MPG_BA_C_DATA, 32'h05, `MPG_RESP_OKAY);
    wr(`MPG_BA_C_DIR, 32'h0F, `MPG_RESP_OKAY);
    wr(`MPG_BA_C_PU, 32'h7F, `MPG_RESP_OKAY);
    settle;
    chk({25'h0, pin_drive.c_pu}, 32'h70);
    rdck(`MPG_BA_C_DATA, 32'h75, `MPG_RESP_OKAY);
    wr(`MPG_BA_C_PU, 32'h00, `MPG_RESP_OKAY);
    settle;
    chk({25'h0, pin_drive.c_pu}, 32'h00);
  endtask : t_third

  task automatic t_fifth;
    ext.e <= 5'h0A;
    ext_oe.e <= 5'h1A;
    wr(`MPG_BA_E_DATA, 32'hFF, `MPG_RESP_OKAY);
    wr(`MPG_BA_E_DIR, 32'h05, `MPG_RESP_OKAY);
    settle;
    rdck(`MPG_BA_E_DATA, 32'h0F, `MPG_RESP_OKAY);
    wr(`MPG_BA_E_DATA, 32'h00, `MPG_RESP_OKAY);
    settle;
    rdck(`MPG_BA_E_DATA, 32'h0A, `MPG_RESP_OKAY);
  endtask : t_fifth

  // Timer, serial and async ownership, then master mode, then release
  task automatic t_handover;
    ext.d <= 8'hFF;
    ext_oe.d <= 8'h31;
    wr(`MPG_BA_D_DATA, 32'hC3, `MPG_RESP_OKAY);
    wr(`MPG_BA_D_DIR, 32'h0E, `MPG_RESP_OKAY);
    wr(`MPG_BA_E_DIR, 32'h00, `MPG_RESP_OKAY);
    wr(`MPG_BA_CTRL, 32'h2D, `MPG_RESP_OKAY);
    settle;
    chk({24'h0, pin_drive.d_oe}, 32'hCF);
    chk({24'h0, pin_drive.d_out}, 32'h4A);
    chk({24'h0, pin_levels.d}, 32'h7A);
    rdck(`MPG_BA_D_DATA, 32'h72, `MPG_RESP_OKAY);
    chk({27'h0, pin_drive.e_oe}, 32'h03);
    chk({27'h0, pin_drive.e_out}, 32'h03);
    wr(`MPG_BA_CTRL, 32'h2F, `MPG_RESP_OKAY);
    settle;
    chk({24'h0, pin_drive.d_oe}, 32'hCE);
    wr(`MPG_BA_CTRL, 32'h00, `MPG_RESP_OKAY);
    settle;
    chk({24'h0, pin_drive.d_oe}, 32'h0E);
    chk({27'h0, pin_drive.e_oe}, 32'h00);
  endtask : t_handover

  task automatic t_osc;
    wr(`MPG_BA_E_DATA, 32'h18, `MPG_RESP_OKAY);
    wr(`MPG_BA_E_DIR, 32'h18, `MPG_RESP_OKAY);
    wr(`MPG_BA_CTRL, 32'h380, `MPG_RESP_OKAY);
    settle;
    chk({27'h0, pin_drive.e_oe}, 32'h08);
    chk({27'h0, pin_drive.e_out}, 32'h08);
    wr(`MPG_BA_E_DATA, 32'h00, `MPG_RESP_OKAY);
    wr(`MPG_BA_CTRL, 32'h00, `MPG_RESP_OKAY);
    settle;
    chk({27'h0, pin_drive.e_out}, 32'h18);
  endtask : t_osc

  // Latches survive a mid-run reset while control registers clear
  task automatic t_reset_keep;
    wr(`MPG_BA_E_DATA, 32'h15, `MPG_RESP_OKAY);
    do_reset;
    t_reset_values;
    wr(`MPG_BA_D_DIR, 32'hFF, `MPG_RESP_OKAY);
    wr(`MPG_BA_E_DIR, 32'h1F, `MPG_RESP_OKAY);
    rdck(`MPG_BA_D_DATA, 32'hC3, `MPG_RESP_OKAY);
    rdck(`MPG_BA_E_DATA, 32'h15, `MPG_RESP_OKAY);
  endtask : t_reset_keep

  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    ext = '0;
    ext_oe = '1;
    alt_drive = {8'h5A, 8'hFF, 5'h1F, 5'h03};
    do_reset;
    t_reset_values;
    t_fourth;
    t_third;
    t_fifth;
    t_handover;
    t_osc;
    rdck(12'hFFC, 32'h0, `MPG_RESP_SLVERR);
    wr(12'hFFC, 32'hFF, `MPG_RESP_SLVERR);
    t_reset_keep;
    tally_and_finish;
  end

  // Watchdog cuts a hang short
  initial begin
    #500000;
    errors++;
    $display("Watchdog expired at t=%0t", $time);
    tally_and_finish;
  end
endmodule : tb_multi_port_gpio_pin_logic
